/* rtl/oac_attr_out.v */
// osd character attribute, border, solid space and luminance outputs
//
// Function
// - caption mode underline drawn on cell lines 22 and 23
// - underline uses the font palette colour of its cell
// - flash only in caption mode, enabled per character bit
// - flash area bit 0: only font and underline blink
// - flash area bit 1: rgb and primary blink; solid space rgb only
// - flash timer in vsync periods: on 24 or 48, off 8
// - caption italic slants right; italic with flash blinks
// - secondary luminance output never flashes
// - slant in 5 steps of 1 dot, or 10 steps of half a dot at prediv 2
// - slant moves font boundary, background boundary stays vertical
// - neighbours of an italic character are slanted too
// - italic overhang into a flashing cell blinks with it
// - last column italic overhang suppressed when solid space off
// - block modes: all-round or shadow border, on when any of the 3 block enable bits is set
// - border shows on primary output in black palette 8
// - border one predivided dot wide, 1.5 at prediv 2 wide dots
// - font beats border, border beats background, none outside cell
// - auto solid space blanks cells and sides, except code 009h with a blank font
// - blank select bit chooses primary or secondary solid space
// - solid space on primary forces background palette 8
// - a non-blank font on code 009h is displayed
`timescale 1ns/1ps
`include "oac_defs.vh"

module oac_attr_out #(
    parameter CODE_W = 10
) (
    input  wire              ref_clk_i,
    input  wire              rst_i,
    // apb slave
    input  wire              psel_i,
    input  wire              penable_i,
    input  wire              pwrite_i,
    input  wire [11:0]       paddr_i,
    input  wire [31:0]       pwdata_i,
    output wire              pready_o,
    output wire              pslverr_o,
    output reg  [31:0]       prdata_o,
    // video timing, from pins
    input  wire              vsync_i,
    // pixel stream, same clock domain
    input  wire              pix_valid_i,
    input  wire              caption_mode_i,
    input  wire              block_display_mode_i,
    input  wire              side_area_i,
    input  wire [5:0]        col_i,
    input  wire [4:0]        line_i,
    input  wire [4:0]        dot_i,
    input  wire [CODE_W-1:0] code_i,
    input  wire              font_blank_i,
    input  wire              font_pix_i,
    input  wire              font_left_i,
    input  wire              font_right_i,
    input  wire              font_above_i,
    input  wire              font_below_i,
    input  wire              wide_dot_i,
    input  wire [3:0]        font_pal_i,
    input  wire [3:0]        bg_pal_i,
    input  wire              italic_attr_bit,
    input  wire              italic_left_i,
    input  wire              italic_right_i,
    input  wire              flash_attr_bit,
    input  wire              flash_left_i,
    input  wire              underline_attr_bit,
    input  wire              secondary_luma_char_bit,
    input  wire [2:0]        block_border_en_i,
    // outputs to the video mixer
    output reg               pix_on_o,
    output reg  [3:0]        pix_pal_o,
    output reg               shift_half_o,
    output reg  [2:0]        shift_dots_o,
    output reg               luma_ctrl_primary,
    output reg               luma_ctrl_secondary
);

////////////////////////////////////////////////////////////////////////////
// registers and apb slave

// control and status state
reg  [7:0] ctrl1;
reg  [7:0] ctrl2;
reg  [7:0] ctrl3;
reg        flash_phase_on;

wire       apb_wr = psel_i & penable_i & pwrite_i;

// zero wait states, never an error
assign pready_o  = 1'b1;
assign pslverr_o = 1'b0;

// write strobe for one register offset, taken at the access phase
function wr_hit;
    input        wr;
    input [11:0] addr;
    input [11:0] off;
    begin
        wr_hit = wr & (addr == off);
    end
endfunction

// control register 1: border style, flash area, solid space
always @(posedge ref_clk_i) begin
    if (rst_i)
        ctrl1 <= `OAC_CTRL_RESET;
    else if (wr_hit(apb_wr, paddr_i, `OAC_ADDR_CTRL1))
        ctrl1 <= pwdata_i[7:0];
end

// control register 2: blanking output select
always @(posedge ref_clk_i) begin
    if (rst_i)
        ctrl2 <= `OAC_CTRL_RESET;
    else if (wr_hit(apb_wr, paddr_i, `OAC_ADDR_CTRL2))
        ctrl2 <= pwdata_i[7:0];
end

// control register 3: flash period, predivide, row length
always @(posedge ref_clk_i) begin
    if (rst_i)
        ctrl3 <= `OAC_CTRL_RESET;
    else if (wr_hit(apb_wr, paddr_i, `OAC_ADDR_CTRL3))
        ctrl3 <= pwdata_i[7:0];
end

reg  [31:0] next_prdata;

// read mux, unmapped reads as zero
always @* begin
    case (paddr_i)
        `OAC_ADDR_CTRL1:  next_prdata = {24'h000000, ctrl1};
        `OAC_ADDR_CTRL2:  next_prdata = {24'h000000, ctrl2};
        `OAC_ADDR_CTRL3:  next_prdata = {24'h000000, ctrl3};
        `OAC_ADDR_STATUS: next_prdata = {31'h00000000, flash_phase_on};
        default:          next_prdata = 32'h00000000;
    endcase
end

// read data caught in the setup cycle, so it stands through the access
always @(posedge ref_clk_i) begin
    if (rst_i)
        prdata_o <= 32'h00000000;
    else if (psel_i & ~penable_i)
        prdata_o <= next_prdata;
end

// control fields picked out of the registers
wire shadow_mode = ctrl1[`OAC_C1_BORDER_SHADOW];
wire flash_area  = ctrl1[`OAC_C1_FLASH_AREA];
wire solid_space_on_bit = ctrl1[`OAC_C1_SOLID_SPACE];
wire blank_sel   = ctrl2[`OAC_C2_BLANK_SEL];
wire flash_long  = ctrl3[`OAC_C3_FLASH_LONG];
wire prediv2     = ctrl3[`OAC_C3_PREDIV2];
wire chars42     = ctrl3[`OAC_C3_CHARS42];

////////////////////////////////////////////////////////////////////////////
// flash timer on vsync

// vsync synchroniser and period counter state
reg        vs_meta;
reg        vs_sync;
reg        vs_last;
reg  [5:0] flash_cnt;
wire       vs_rise = vs_sync & ~vs_last;

// two-stage synchroniser; only the second stage feeds logic
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        vs_meta <= 1'b0;
        vs_sync <= 1'b0;
        vs_last <= 1'b0;
    end else begin
        vs_meta <= vs_in_pin(vsync_i);
        vs_sync <= vs_meta;
        vs_last <= vs_sync;
    end
end

// pin value as the first stage sees it
function vs_in_pin;
    input v;
    begin
        vs_in_pin = v;
    end
endfunction

reg  [5:0] next_flash_cnt;
reg        next_flash_on;
wire [5:0] on_len    = flash_long ? `OAC_FLASH_ON_LONG : `OAC_FLASH_ON_SHORT;
wire [5:0] phase_len = flash_phase_on ? on_len : `OAC_FLASH_OFF;

// phase length compared on every vsync, so a mid-phase change applies at once
always @* begin
    next_flash_cnt = flash_cnt;
    next_flash_on  = flash_phase_on;
    if (vs_rise) begin
        if (flash_cnt >= phase_len - 6'd1) begin
            next_flash_cnt = 6'd0;
            next_flash_on  = ~flash_phase_on;
        end else begin
            next_flash_cnt = flash_cnt + 6'd1;
        end
    end
end

// on phase comes first after reset; one count per vsync period
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        flash_cnt      <= 6'd0;
        flash_phase_on <= 1'b1;
    end else begin
        flash_cnt      <= next_flash_cnt;
        flash_phase_on <= next_flash_on;
    end
end

////////////////////////////////////////////////////////////////////////////
// italic slant

// lines below the slant step shift right less; bottom line unshifted
function [3:0] slant_of;
    input [4:0] ln;
    input       half;
    reg   [4:0] rev;
    reg   [6:0] steps;
    begin
        rev = 5'd23 - ln;
        if (ln > 5'd23)
            rev = 5'd0;
        // five steps of one dot, or ten steps of half a dot
        if (half) begin
            steps    = ({2'b00, rev} * 7'd5) / 7'd12;
            slant_of = steps[3:0];
        end else begin
            steps    = {2'b00, rev} / 7'd5;
            slant_of = {steps[2:0], 1'b0};
        end
    end
endfunction

// dot still under the overhang at the left edge of a slanted cell
function in_overhang;
    input [4:0] dot;
    input [3:0] hd;
    begin
        in_overhang = dot < {1'b0, hd};
    end
endfunction

// column and cell qualifiers

wire        cap       = caption_mode_i;
wire        last_col  = col_i == (chars42 ? `OAC_LAST_COL_42
                                          : `OAC_LAST_COL_32);
// neighbouring italic drags this cell into slant as well
wire        slanted   = cap & (italic_attr_bit | italic_left_i |
                               italic_right_i);
wire [3:0]  slant_hd  = slanted ? slant_of(line_i, prediv2) : 4'd0;
// overhang from a non-flashing italic left neighbour
wire        overhang  = cap & italic_left_i & ~flash_left_i & font_pix_i &
                        in_overhang(dot_i, slant_hd);
// past the last column nothing of the slant is kept without solid space
wire        clip      = slanted & last_col & ~solid_space_on_bit &
                        in_overhang(dot_i, slant_hd) &
                        italic_attr_bit;

////////////////////////////////////////////////////////////////////////////
// per pixel composition

wire ul_line  = (line_i == `OAC_UL_LINE_A) | (line_i == `OAC_UL_LINE_B);
wire ul_pix   = cap & underline_attr_bit & ul_line;
wire fnt      = (font_pix_i & ~clip) | ul_pix;
localparam [CODE_W-1:0] BLANK_CODE = `OAC_BLANK_CODE;
wire is_blank = code_i == BLANK_CODE;
wire blank_ok = is_blank & font_blank_i;
wire ss_cell  = cap & solid_space_on_bit &
                ((pix_valid_i & ~blank_ok) | side_area_i);
wire flashing = cap & flash_attr_bit & ~flash_phase_on;
wire blink_ov = overhang & flash_attr_bit & ~flash_phase_on;

// border from neighbour font pixels, in block modes only
wire brd_en   = block_display_mode_i & (|block_border_en_i);
wire nb_shad  = font_left_i | font_above_i;
wire nb_all   = nb_shad | font_right_i | font_below_i;
wire brd_pix  = brd_en & pix_valid_i & ~font_pix_i &
                (shadow_mode ? nb_shad : nb_all);

// composed values for the output stage
reg       next_on;
reg [3:0] next_pal;
reg       next_p1;
reg       next_p2;

// priority: font, then border, then background
always @* begin
    next_on  = 1'b0;
    next_pal = 4'h0;
    next_p1  = 1'b0;
    next_p2  = 1'b0;
    if (pix_valid_i & fnt) begin
        next_on  = 1'b1;
        next_pal = font_pal_i;
    end else if (brd_pix) begin
        next_on  = 1'b1;
        next_pal = `OAC_PAL_BLACK;
    end else if (pix_valid_i) begin
        next_on  = 1'b1;
        next_pal = bg_pal_i;
        if (ss_cell & ~blank_sel)
            next_pal = `OAC_PAL_BLACK;
    end
    // primary luminance: with solid space on the primary output it marks only that area
    if (cap & solid_space_on_bit & ~blank_sel)
        next_p1 = ss_cell;
    else
        next_p1 = next_on;
    // secondary never blinks
    next_p2 = (pix_valid_i & secondary_luma_char_bit) |
              (ss_cell & blank_sel);
    // flash gating
    if (flashing) begin
        if (!flash_area) begin
            if (pix_valid_i & fnt) begin
                next_on = 1'b0;
                if (!ss_cell)
                    next_p1 = 1'b0;
            end
        end else begin
            if (pix_valid_i) begin
                next_on = 1'b0;
                if (!ss_cell)
                    next_p1 = 1'b0;
            end
        end
    end
    if (blink_ov & flash_area)
        next_on = 1'b0;
end

// colour and palette of the dot, one cycle behind the pixel inputs
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        pix_on_o  <= 1'b0;
        pix_pal_o <= 4'h0;
    end else begin
        pix_on_o  <= next_on;
        pix_pal_o <= next_pal;
    end
end

// slant shift and border width: half-dot extra only at prediv 2, for the border only with 1.5 wide dots
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        shift_half_o <= 1'b0;
        shift_dots_o <= 3'd0;
    end else begin
        shift_half_o <= slant_hd[0] |
                        (brd_pix & prediv2 & wide_dot_i);
        shift_dots_o <= slant_hd[3:1];
    end
end

// luminance controls kept in step with the colour they belong to
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        luma_ctrl_primary   <= 1'b0;
        luma_ctrl_secondary <= 1'b0;
    end else begin
        luma_ctrl_primary   <= next_p1;
        luma_ctrl_secondary <= next_p2;
    end
end

endmodule

/* shared/oac_defs.vh */
// constants for the osd attribute and luminance output block
`ifndef OAC_DEFS_VH
`define OAC_DEFS_VH
// apb register byte offsets
`define OAC_ADDR_CTRL1      12'h000
`define OAC_ADDR_CTRL2      12'h004
`define OAC_ADDR_CTRL3      12'h008
`define OAC_ADDR_STATUS     12'h00c
// control register 1 fields
`define OAC_C1_BORDER_SHADOW 2
`define OAC_C1_FLASH_AREA    3
`define OAC_C1_SOLID_SPACE   4
// control register 2 fields
`define OAC_C2_BLANK_SEL     3
// control register 3 fields
`define OAC_C3_FLASH_LONG    4
`define OAC_C3_PREDIV2       5
`define OAC_C3_CHARS42       6
// reset values
`define OAC_CTRL_RESET      8'h00
// flash timing in vsync periods
`define OAC_FLASH_ON_SHORT  6'd24
`define OAC_FLASH_ON_LONG   6'd48
`define OAC_FLASH_OFF       6'd8
// cell geometry
`define OAC_UL_LINE_A       5'd22
`define OAC_UL_LINE_B       5'd23
`define OAC_BLANK_CODE      10'h009
`define OAC_LAST_COL_32     6'd31
`define OAC_LAST_COL_42     6'd41
`define OAC_PAL_BLACK       4'h8
`endif

/* testbench/oac_attr_props.sv */
// concurrent checks on the osd attribute output block
`timescale 1ns/1ps
module oac_attr_props (
    input logic       ref_clk_i,
    input logic       rst_i,
    input logic       pix_valid_i,
    input logic       caption_mode_i,
    input logic       block_display_mode_i,
    input logic       side_area_i,
    input logic [4:0] line_i,
    input logic       font_pix_i,
    input logic [3:0] font_pal_i,
    input logic       italic_attr_bit,
    input logic       flash_attr_bit,
    input logic       underline_attr_bit,
    input logic       secondary_luma_char_bit,
    input logic       pix_on_o,
    input logic [3:0] pix_pal_o,
    input logic       shift_half_o,
    input logic [2:0] shift_dots_o,
    input logic       luma_ctrl_secondary
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // in-area cell pixels; side areas left out, they only carry blanking
    wire cap_cell = caption_mode_i & pix_valid_i & ~side_area_i;
    wire blk_cell = block_display_mode_i & pix_valid_i & ~side_area_i;
    sequence s_ul_cell;
        cap_cell && underline_attr_bit && !flash_attr_bit
            && !italic_attr_bit && line_i inside {5'd22, 5'd23};
    endsequence
    sequence s_font_lit;
        pix_on_o && pix_pal_o == $past(font_pal_i);
    endsequence
    ////////////////////////////////////////////////////////////////////
    chk_ul_draw:
        assert property (s_ul_cell |=> pix_on_o) else $error("no underline");
    chk_ul_colour:
        assert property (s_ul_cell |=> s_font_lit) else $error("ul colour");
    chk_sec_steady:
        assert property (cap_cell && secondary_luma_char_bit
            |=> luma_ctrl_secondary) else $error("secondary dropped");
    chk_font_wins:
        assert property (blk_cell && font_pix_i |=> s_font_lit)
            else $error("font lost");
    chk_blk_noflash:
        assert property (blk_cell && font_pix_i && flash_attr_bit
            |=> pix_on_o) else $error("block mode blinked");
    chk_outside_dark:
        assert property (!pix_valid_i && !side_area_i |=> !pix_on_o)
            else $error("pixel outside area");
    chk_slant_bottom:
        assert property (cap_cell && italic_attr_bit && line_i == 5'd23
            |=> shift_dots_o == 3'h0 && !shift_half_o)
            else $error("bottom line slanted");
    chk_blk_upright:
        assert property (blk_cell |=> shift_dots_o == 3'h0)
            else $error("block mode slanted");
endmodule
bind oac_attr_out oac_attr_props i_oac_attr_props (
    .ref_clk_i, .rst_i, .pix_valid_i, .caption_mode_i,
    .block_display_mode_i, .side_area_i, .line_i, .font_pix_i,
    .font_pal_i, .italic_attr_bit, .flash_attr_bit, .underline_attr_bit,
    .secondary_luma_char_bit, .pix_on_o, .pix_pal_o, .shift_half_o,
    .shift_dots_o, .luma_ctrl_secondary
);

/* testbench/oac_mixer_model.sv */
// behavioural model of the external video mixer
`timescale 1ns/1ps
module oac_mixer_model (
    input  logic ref_clk_i,
    input  logic luma_ctrl_primary,
    input  logic luma_ctrl_secondary,
    output logic dim_o
);
    // picture darkened wherever either control is high, one cycle late
    always @(posedge ref_clk_i) begin
        dim_o <= luma_ctrl_primary | luma_ctrl_secondary;
    end
endmodule

/* testbench/osd_attribute_output_control_tb.sv */
// self-checking bench for the osd attribute and luminance output block
`timescale 1ns/1ps
`include "oac_defs.vh"
module osd_attribute_output_control_tb;
    logic        ref_clk_i, rst_i, psel_i, penable_i, pwrite_i, vsync_i;
    logic        pready_o, pslverr_o, pix_valid_i, caption_mode_i;
    logic        block_display_mode_i, side_area_i, font_blank_i, wide_dot_i;
    logic        font_pix_i, font_left_i, font_right_i, font_above_i;
    logic        font_below_i, italic_attr_bit, italic_left_i, dim;
    logic        italic_right_i, flash_attr_bit, flash_left_i, pix_on_o;
    logic        underline_attr_bit, secondary_luma_char_bit, shift_half_o;
    logic        luma_ctrl_primary, luma_ctrl_secondary;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [5:0]  col_i;
    logic [4:0]  line_i, dot_i;
    logic [9:0]  code_i;
    logic [3:0]  font_pal_i, bg_pal_i, pix_pal_o;
    logic [2:0]  block_border_en_i, shift_dots_o;
    int          errors, checked, cyc;
    oac_attr_out i_oac_attr_out (.*);
    oac_mixer_model i_oac_mixer_model (.ref_clk_i, .luma_ctrl_primary,
        .luma_ctrl_secondary, .dim_o(dim));
    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // hang guard: whole run needs well under 2000 cycles
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            complete_run;
        end
    end
    task ck(input [31:0] s, input [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one apb transfer; a free cycle after keeps psel from double driving
    task acc(input w, input [11:0] a, input [31:0] d);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        // pready and read data looked at settled, before the closing edge
        @(negedge ref_clk_i);
        while (pready_o !== 1'b1) @(negedge ref_clk_i);
        rd = prdata_o;
        @(posedge ref_clk_i);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task vs(input int n);
        repeat (n) begin
            vsync_i <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
            vsync_i <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask
    task phase(input int n, input [31:0] e);
        vs(n);
        acc(1'b0, `OAC_ADDR_STATUS, 32'h0);
        ck(rd[0], e);
    endtask
    // held three edges so the mixer output has landed too
    task px;
        repeat (3) @(posedge ref_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////
    task regs_check;
        acc(1'b0, `OAC_ADDR_CTRL1, 32'h0);
        ck(rd, 32'h0);
        acc(1'b1, `OAC_ADDR_CTRL1, 32'hffff_ff1c);
        acc(1'b0, `OAC_ADDR_CTRL1, 32'h0);
        ck(rd, 32'h1c);
        acc(1'b1, 12'h020, 32'hff);
        acc(1'b0, 12'h020, 32'h0);
        ck(rd, 32'h0);
        ck(pslverr_o, 32'h0);
        acc(1'b1, `OAC_ADDR_CTRL1, 32'h0);
    endtask
    task flash_check;
        phase(23, 32'h1);
        phase(1, 32'h0);
        // slant test uses no right-column font pixel
        caption_mode_i          <= 1'b1;
        pix_valid_i             <= 1'b1;
        font_pix_i              <= 1'b1;
        flash_attr_bit          <= 1'b1;
        italic_attr_bit         <= 1'b1;
        line_i                  <= 5'd23;
        secondary_luma_char_bit <= 1'b1;
        px;
        ck(pix_on_o, 32'h0);
        ck(luma_ctrl_secondary, 32'h1);
        ck(shift_dots_o, 32'h0);
        caption_mode_i       <= 1'b0;
        block_display_mode_i <= 1'b1;
        font_pal_i           <= 4'h5;
        block_border_en_i    <= 3'h7;
        px;
        ck(pix_on_o, 32'h1);
        ck(pix_pal_o, 32'h5);
        block_display_mode_i <= 1'b0;
        acc(1'b1, `OAC_ADDR_CTRL3, 32'h10);
        phase(7, 32'h0);
        phase(1, 32'h1);
        phase(47, 32'h1);
        phase(1, 32'h0);
    endtask
    task underline_check;
        caption_mode_i     <= 1'b1;
        flash_attr_bit     <= 1'b0;
        italic_attr_bit    <= 1'b0;
        font_pix_i         <= 1'b0;
        underline_attr_bit <= 1'b1;
        font_pal_i         <= 4'h9;
        bg_pal_i           <= 4'h3;
        line_i             <= 5'd22;
        px;
        ck(pix_on_o, 32'h1);
        ck(pix_pal_o, 32'h9);
        // off the underline lines only the background colour shows
        line_i <= 5'd21;
        px;
        ck(pix_pal_o, 32'h3);
    endtask
    task solid_check;
        underline_attr_bit      <= 1'b0;
        secondary_luma_char_bit <= 1'b0;
        code_i                  <= 10'h010;
        acc(1'b1, `OAC_ADDR_CTRL1, 32'h10);
        px;
        ck(luma_ctrl_primary, 32'h1);
        ck(luma_ctrl_secondary, 32'h0);
        ck(dim, 32'h1);
        code_i       <= 10'h009;
        font_blank_i <= 1'b1;
        px;
        ck(luma_ctrl_primary, 32'h0);
        code_i <= 10'h010;
        acc(1'b1, `OAC_ADDR_CTRL2, 32'h08);
        px;
        ck(luma_ctrl_secondary, 32'h1);
    endtask
    task complete_run;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, vsync_i} = '0;
        {pix_valid_i, caption_mode_i, block_display_mode_i, side_area_i,
         col_i, line_i, dot_i, code_i, font_blank_i, font_pix_i} = '0;
        {font_left_i, font_right_i, font_above_i, font_below_i, wide_dot_i,
         font_pal_i, bg_pal_i, italic_attr_bit, italic_left_i} = '0;
        {italic_right_i, flash_attr_bit, flash_left_i, underline_attr_bit,
         secondary_luma_char_bit, block_border_en_i} = '0;
        errors  = 0;
        checked = 0;
        cyc     = 0;
        rst_i   = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        regs_check;
        flash_check;
        underline_check;
        solid_check;
        complete_run;
    end
endmodule
